// *** core_exec_params.svh ***
// Purpose: Offsets, field positions, reset values and timing counts for the
//          return and rotate execution block.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Definitions only.
`ifndef CORE_EXEC_PARAMS_SVH
`define CORE_EXEC_PARAMS_SVH

`define ADDR_INSTR 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_WREG 8'h08
`define ADDR_PC 8'h0c
`define ADDR_INTCTL 8'h10
`define ADDR_STACK_PUSH 8'h14
`define ADDR_STACK_TOP 8'h18
`define ADDR_FILE_SEL 8'h1c
`define ADDR_FILE_DATA 8'h20

`define IRQ_ENABLE_BIT 7
`define ST_BUSY_BIT 0
`define ST_CARRY_BIT 1
`define ST_REFUSED_BIT 2
`define ST_ILLEGAL_BIT 3
`define ST_DEPTH_LSB 4
`define DEST_BIT 7

`define OPC_RETURN 14'h0008
`define OPC_INTERRUPT_RETURN 14'h0009
`define OPC_LITERAL_RETURN_MASK 14'h3c00
`define OPC_LITERAL_RETURN_MATCH 14'h3400
`define OPC_ROTATE_LEFT_MASK 14'h3f00
`define OPC_ROTATE_LEFT_MATCH 14'h0d00

`define RST_WREG 8'h00
`define RST_PC 13'h0000
`define RST_INTCTL 8'h00

`define RETURN_CYCLES 2
`define ROTATE_CYCLES 1

`endif

// *** core_exec_pkg.sv ***
// Purpose: Types shared by the execution block and its helpers.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are one-hot.
package core_exec_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_FIRST = 3'b010,
    ST_SECOND = 3'b100
  } exec_state_t;

  typedef enum logic [2:0]
  {
    OP_NONE = 3'h0,
    OP_RETURN = 3'h1,
    OP_INTERRUPT_RETURN = 3'h2,
    OP_LITERAL_RETURN = 3'h3,
    OP_ROTATE_LEFT = 3'h4
  } op_kind_t;

endpackage

// *** stack_if.sv ***
// Purpose: Carries push, pop and top-of-stack between core and return stack.
// Assumes: One clock domain.
// Notes:   Push and pop are one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
interface stack_if #(parameter int PCW = 13, parameter int DW = 4);
  logic push;
  logic pop;
  logic [PCW-1:0] push_data;
  logic [PCW-1:0] stack_top_value;
  logic [DW-1:0] depth;
  modport core (output push, output pop, output push_data,
                input stack_top_value, input depth);
  modport store (input push, input pop, input push_data,
                 output stack_top_value, output depth);
endinterface
`default_nettype wire

// *** return_stack.sv ***
// Purpose: Circular hardware return stack.
// Assumes: Push and pop never arrive in the same cycle.
// Notes:   Overflow overwrites the oldest entry and underflow wraps.
`timescale 1ns/100ps
`default_nettype none
module return_stack
  import core_exec_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int PCW = 13,
  parameter int PTRW = 3
)
(
  input wire logic clk,
  input wire logic rst_n,
  stack_if.store sp
);
  typedef struct packed
  {
    logic [DEPTH-1:0][PCW-1:0] ent;
    logic [PTRW-1:0] ptr;
    logic [PTRW:0] depth;
  } stack_state_t;

  stack_state_t s_q;
  stack_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (sp.push)
    begin
      s_d.ent[s_q.ptr] = sp.push_data;
      s_d.ptr = s_q.ptr + 1'b1;
      if (s_q.depth != (PTRW+1)'(DEPTH))
        s_d.depth = s_q.depth + 1'b1;
    end
    else if (sp.pop)
    begin
      s_d.ptr = s_q.ptr - 1'b1;
      if (s_q.depth != '0)
        s_d.depth = s_q.depth - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sp.stack_top_value = s_q.ent[s_q.ptr - 1'b1];
  assign sp.depth = s_q.depth;
endmodule
`default_nettype wire

// *** rotate_left_unit.sv ***
// Purpose: Rotate one byte left through the carry flag.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   None.
`timescale 1ns/100ps
`default_nettype none
module rotate_left_unit
#(
  parameter int WIDTH = 8
)
(
  input wire logic [WIDTH-1:0] value,
  input wire logic carry_in,
  output logic [WIDTH-1:0] result,
  output logic carry_out
);
  // The old carry enters bit 0 and the top bit leaves into carry.
  assign result = {value[WIDTH-2:0], carry_in};
  assign carry_out = value[WIDTH-1];
endmodule
`default_nettype wire

// *** return_rotate_exec.sv ***
// Purpose: Executes the three return instructions and rotate-left-through-
//          carry for a small 8-bit core, with its state reached over APB.
// Assumes: pclk at 40 MHz; APB master of the usual kind; zero-wait slave.
// Notes:   Registers that an instruction can change are locked while busy, except the illegal flag, whose clear still lands.
//          Opcodes outside the four instructions run as one-cycle no-ops that
//          raise the illegal flag. The stack is circular, so an underflow
//          returns to a stale address without warning.
//
// Summary of operation
// - Interrupt return pops the stack and loads the PC with the popped top.
// - Interrupt return sets global_irq_enable, bit 7; one word, two cycles.
// - Literal return loads the working register with its 8-bit immediate.
// - Literal return reloads PC from stack top; two cycles, flags untouched.
// - Subroutine return pops the stack into PC; two cycles, flags untouched.
// - Rotate left shifts the file register through carry; only carry changes.
// - Rotate destination 0 writes W, 1 writes the file register; one cycle.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "core_exec_params.svh"
module return_rotate_exec
  import core_exec_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PCW = 13,
  parameter int STACK_DEPTH = 8,
  parameter int FILE_DEPTH = 128
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [PCW-1:0] pc_out,
  output logic global_irq_enable,
  output logic busy
);
  localparam int FAW = $clog2(FILE_DEPTH);
  localparam int PTRW = $clog2(STACK_DEPTH);
  localparam int DW = PTRW + 1;
  // Return length in cycles, cut to the width of the cycle counter.
  localparam logic [1:0] RETURN_CNT = 2'(`RETURN_CYCLES);

  // All state sits in one record: one process forms its next value, one registers it.
  typedef struct packed
  {
    exec_state_t fsm;
    logic [1:0] cyc;
    logic [13:0] instr;
    logic [PCW-1:0] pc;
    logic [7:0] wreg;
    logic carry;
    logic [7:0] interrupt_control_reg;
    logic refused;
    logic illegal;
    logic [FAW-1:0] fsel;
    logic [FILE_DEPTH-1:0][7:0] file_mem;
    logic [31:0] rdata;
    logic slverr;
  } exec_state_s_t;

  localparam exec_state_s_t RESET_STATE = '{
    fsm: ST_IDLE,
    cyc: 2'h0,
    instr: 14'h0000,
    pc: `RST_PC,
    wreg: `RST_WREG,
    carry: 1'b0,
    interrupt_control_reg: `RST_INTCTL,
    refused: 1'b0,
    illegal: 1'b0,
    fsel: '0,
    file_mem: '0,
    rdata: 32'h0000_0000,
    slverr: 1'b0
  };

  exec_state_s_t s_q;
  exec_state_s_t s_d;
  op_kind_t op;
  logic setup;
  logic access;
  logic [7:0] rot_in;
  logic [7:0] rot_out;
  logic rot_carry;
  logic [FAW-1:0] f_addr;
  logic wr_commit;
  logic exec_idle;

  // The stack sits behind an interface so its push, pop and top travel together.
  stack_if #(.PCW(PCW), .DW(DW)) sp ();

  return_stack #(
    .DEPTH(STACK_DEPTH),
    .PCW(PCW),
    .PTRW(PTRW)
  ) u_stack (
    .clk(pclk),
    .rst_n(presetn),
    .sp(sp)
  );

  rotate_left_unit #(
    .WIDTH(8)
  ) u_rot (
    .value(rot_in),
    .carry_in(s_q.carry),
    .result(rot_out),
    .carry_out(rot_carry)
  );

  // Setup and access come from bus pins of this same clock domain.
  assign setup = psel & ~penable;
  assign access = psel & penable;
  // A write whose setup found no register is dropped at the access edge.
  assign wr_commit = access & pwrite & ~s_q.slverr;
  assign exec_idle = (s_q.fsm == ST_IDLE);
  // The file address is the low opcode bits; the destination bit sits above them.
  assign f_addr = s_q.instr[FAW-1:0];
  assign rot_in = s_q.file_mem[f_addr];

  // Decode reads the latched opcode, which stays locked while the instruction runs.
  always_comb
  begin
    if ((s_q.instr & `OPC_ROTATE_LEFT_MASK) == `OPC_ROTATE_LEFT_MATCH)
      op = OP_ROTATE_LEFT;
    else if ((s_q.instr & `OPC_LITERAL_RETURN_MASK) == `OPC_LITERAL_RETURN_MATCH)
      op = OP_LITERAL_RETURN;
    else if (s_q.instr == `OPC_INTERRUPT_RETURN)
      op = OP_INTERRUPT_RETURN;
    else if (s_q.instr == `OPC_RETURN)
      op = OP_RETURN;
    else
      op = OP_NONE;
  end

  always_comb
  begin
    s_d = s_q;
    sp.push = 1'b0;
    sp.pop = 1'b0;
    sp.push_data = '0;

    // Read data and the error answer are latched in the setup cycle so the
    // access phase can complete with no wait state.
    if (setup)
    begin
      s_d.slverr = 1'b0;
      // Unused high bits read as zero.
      s_d.rdata = 32'h0000_0000;
      unique case (paddr)
        `ADDR_INSTR: s_d.rdata[13:0] = s_q.instr;
        `ADDR_STATUS:
        begin
          s_d.rdata[`ST_BUSY_BIT] = !exec_idle;
          s_d.rdata[`ST_CARRY_BIT] = s_q.carry;
          s_d.rdata[`ST_REFUSED_BIT] = s_q.refused;
          s_d.rdata[`ST_ILLEGAL_BIT] = s_q.illegal;
          s_d.rdata[`ST_DEPTH_LSB +: DW] = sp.depth;
        end
        `ADDR_WREG: s_d.rdata[7:0] = s_q.wreg;
        `ADDR_PC: s_d.rdata[PCW-1:0] = s_q.pc;
        `ADDR_INTCTL: s_d.rdata[7:0] = s_q.interrupt_control_reg;
        `ADDR_STACK_PUSH: s_d.rdata[DW-1:0] = sp.depth;
        `ADDR_STACK_TOP: s_d.rdata[PCW-1:0] = sp.stack_top_value;
        `ADDR_FILE_SEL: s_d.rdata[FAW-1:0] = s_q.fsel;
        `ADDR_FILE_DATA: s_d.rdata[7:0] = s_q.file_mem[s_q.fsel];
        default: s_d.slverr = 1'b1;
      endcase
    end

    // Writes land at the access edge. While an instruction runs, every
    // register it may touch is locked except the illegal flag, whose software clear is still taken.
    if (wr_commit)
    begin
      if (paddr == `ADDR_STATUS)
      begin
        if (pwdata[`ST_REFUSED_BIT])
          s_d.refused = 1'b0;
        if (pwdata[`ST_ILLEGAL_BIT])
          s_d.illegal = 1'b0;
        if (exec_idle)
          s_d.carry = pwdata[`ST_CARRY_BIT];
      end
      // A refused write is dropped whole; software sees only the sticky flag
      // and must repeat the write once the core is idle.
      else if (!exec_idle)
        s_d.refused = 1'b1;
      else
      begin
        unique case (paddr)
          `ADDR_INSTR:
          begin
            s_d.instr = pwdata[13:0];
            s_d.fsm = ST_FIRST;
          end
          `ADDR_WREG: s_d.wreg = pwdata[7:0];
          `ADDR_PC: s_d.pc = pwdata[PCW-1:0];
          `ADDR_INTCTL: s_d.interrupt_control_reg = pwdata[7:0];
          `ADDR_STACK_PUSH:
          begin
            // Bus pushes stand in for the call path, which lives outside this block.
            sp.push = 1'b1;
            sp.push_data = pwdata[PCW-1:0];
          end
          `ADDR_FILE_SEL: s_d.fsel = pwdata[FAW-1:0];
          `ADDR_FILE_DATA: s_d.file_mem[s_q.fsel] = pwdata[7:0];
          default: s_d.refused = s_q.refused;
        endcase
      end
    end

    // Execution comes last so a hardware set beats a software clear.
    unique case (s_q.fsm)
      ST_IDLE:
      begin
        s_d.cyc = 2'h0;
      end
      ST_FIRST:
      begin
        // Every result of an instruction is formed in this first cycle.
        s_d.cyc = 2'h1;
        unique case (op)
          OP_ROTATE_LEFT:
          begin
            if (s_q.instr[`DEST_BIT])
              s_d.file_mem[f_addr] = rot_out;
            else
              s_d.wreg = rot_out;
            // Carry comes from the registered flag, never from a same-cycle bus write.
            s_d.carry = rot_carry;
            s_d.pc = s_q.pc + 1'b1;
            s_d.fsm = ST_IDLE;
          end
          OP_RETURN:
          begin
            // The top is read before the pop lands, so PC takes the return address
            // and not the entry beneath it.
            sp.pop = 1'b1;
            s_d.pc = sp.stack_top_value;
            s_d.fsm = ST_SECOND;
          end
          OP_INTERRUPT_RETURN:
          begin
            sp.pop = 1'b1;
            s_d.pc = sp.stack_top_value;
            // Only the enable bit is set; the other control bits keep their value.
            s_d.interrupt_control_reg[`IRQ_ENABLE_BIT] = 1'b1;
            s_d.fsm = ST_SECOND;
          end
          OP_LITERAL_RETURN:
          begin
            sp.pop = 1'b1;
            s_d.pc = sp.stack_top_value;
            // The literal lands in W with the PC reload; no flag moves.
            s_d.wreg = s_q.instr[7:0];
            s_d.fsm = ST_SECOND;
          end
          OP_NONE:
          begin
            // Anything outside this block's set runs as a no-operation.
            s_d.illegal = 1'b1;
            s_d.pc = s_q.pc + 1'b1;
            s_d.fsm = ST_IDLE;
          end
        endcase
      end
      ST_SECOND:
      begin
        // The second cycle of a return only stalls; flags stay untouched.
        s_d.cyc = s_q.cyc + 1'b1;
        if (s_d.cyc >= RETURN_CNT)
          s_d.fsm = ST_IDLE;
      end
    endcase
  end

  // Reset loads a constant record only, so no reset path depends on other state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= RESET_STATE;
    else
      s_q <= s_d;
  end

  assign prdata = s_q.rdata;
  // The error answer shows only in the access phase, as the bus expects.
  assign pslverr = s_q.slverr & access;
  // Every access completes in its first cycle, so ready needs no state.
  assign pready = access;
  assign pc_out = s_q.pc;
  assign global_irq_enable = s_q.interrupt_control_reg[`IRQ_ENABLE_BIT];
  assign busy = ~exec_idle;
endmodule
`default_nettype wire

// *** return_rotate_exec_sva.sv ***
// Purpose: Port checks of instruction timing and of the PC and interrupt enable.
// Assumes: Zero-wait APB; an instruction write is taken only while idle.
// Notes: Attached by the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
`include "core_exec_params.svh"
module return_rotate_exec_sva
#(
  parameter int ADDR_W = 8,
  parameter int PCW = 13
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PCW-1:0] pc_out,
  input wire logic global_irq_enable,
  input wire logic busy
);
  logic wr_any;
  logic go;
  logic [13:0] op;
  logic lit;
  logic rot;
  logic iret;
  assign wr_any = psel && penable && pwrite;
  assign go = wr_any && paddr == `ADDR_INSTR && !busy;
  assign op = pwdata[13:0];
  assign lit = (op & `OPC_LITERAL_RETURN_MASK) == `OPC_LITERAL_RETURN_MATCH;
  assign rot = (op & `OPC_ROTATE_LEFT_MASK) == `OPC_ROTATE_LEFT_MATCH;
  assign iret = op == `OPC_INTERRUPT_RETURN;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ret_two_cyc: assert property (go && op == 14'h0008 |-> ##1 busy[*2] ##1 !busy)
    else $error("subroutine return length wrong");
  a_irq_two_cyc: assert property (go && op == 14'h0009 |-> ##1 busy[*2] ##1 !busy)
    else $error("interrupt return length wrong");
  a_lit_two_cyc: assert property (go && lit |-> ##1 busy[*2] ##1 !busy)
    else $error("literal return length wrong");
  a_rot_one_cyc: assert property (go && rot |-> ##1 busy ##1 !busy)
    else $error("rotate length wrong");
  a_irq_sets_enable: assert property (go && op == 14'h0009 |-> ##2 global_irq_enable)
    else $error("interrupt enable not set");
  a_flag_keep: assert property (go && !iret |=> $stable(global_irq_enable)[*2])
    else $error("interrupt enable changed");
  a_pc_idle_hold: assert property (!busy && !wr_any |=> $stable(pc_out))
    else $error("pc moved while idle");
  a_irq_en_hold: assert property (!busy && !wr_any |=> $stable(global_irq_enable))
    else $error("interrupt enable moved while idle");
endmodule
bind return_rotate_exec return_rotate_exec_sva #(.ADDR_W(ADDR_W), .PCW(PCW)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pc_out(pc_out), .global_irq_enable(global_irq_enable), .busy(busy));
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Directed bench of the return and rotate instructions over APB.
// Assumes: Zero-wait APB slave; return addresses are pushed over the bus.
// Notes: The loop covers every return kind, both literal extremes.
`timescale 1ns/100ps
`default_nettype none
`include "core_exec_params.svh"
module tb_top;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [12:0] pc_out;
  logic global_irq_enable;
  logic busy;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int cmp_count = 0;
  logic [13:0] ops [4] = '{14'h0008, 14'h0009, 14'h3400, 14'h37ff};
  logic [12:0] tops [4] = '{13'h0123, 13'h1abc, 13'h0777, 13'h1000};
  always #12.5 pclk = ~pclk;
  return_rotate_exec i_return_rotate_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pc_out(pc_out),
    .global_irq_enable(global_irq_enable), .busy(busy));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Waits on busy with a bound so a stuck core still reaches the verdict.
  task automatic exec(input logic [13:0] o);
    xfer(1'h1, `ADDR_INSTR, {18'h0, o});
    repeat (8)
    begin
      @(posedge pclk);
      if (busy === 1'h0)
        break;
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    chk(pc_out, 32'h0);
    xfer(1'h0, 8'h24, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'h1, `ADDR_INTCTL, 32'h0);
      xfer(1'h1, `ADDR_WREG, 32'h5a);
      xfer(1'h1, `ADDR_STATUS, 32'h2);
      xfer(1'h1, `ADDR_STACK_PUSH, {19'h0, tops[i]});
      exec(ops[i]);
      chk(pc_out, tops[i]);
      chk(global_irq_enable, i == 1);
      xfer(1'h0, `ADDR_WREG, 32'h0);
      chk(rd, i > 1 ? {24'h0, ops[i][7:0]} : 32'h5a);
      xfer(1'h0, `ADDR_STATUS, 32'h0);
      chk(rd, 32'h2);
    end
    xfer(1'h1, `ADDR_INTCTL, 32'h80);
    xfer(1'h1, `ADDR_PC, 32'h100);
    xfer(1'h1, `ADDR_STATUS, 32'h0);
    xfer(1'h1, `ADDR_FILE_SEL, 32'h5);
    xfer(1'h1, `ADDR_FILE_DATA, 32'he6);
    exec(14'h0d05);
    xfer(1'h0, `ADDR_WREG, 32'h0);
    chk(rd, 32'hcc);
    xfer(1'h0, `ADDR_FILE_DATA, 32'h0);
    chk(rd, 32'he6);
    exec(14'h0d85);
    xfer(1'h0, `ADDR_FILE_DATA, 32'h0);
    chk(rd, 32'hcd);
    xfer(1'h0, `ADDR_STATUS, 32'h0);
    chk(rd, 32'h2);
    chk(pc_out, 32'h102);
    chk(global_irq_enable, 32'h1);
    xfer(1'h1, `ADDR_STACK_PUSH, 32'h0abc);
    xfer(1'h0, `ADDR_STACK_TOP, 32'h0);
    chk(rd, 32'h0abc);
    exec(14'h0000);
    xfer(1'h0, `ADDR_STATUS, 32'h0);
    chk(rd, 32'h1a);
    chk(pc_out, 32'h103);
    xfer(1'h1, `ADDR_STATUS, 32'ha);
    exec(14'h0008);
    chk(pc_out, 32'h0abc);
    xfer(1'h0, `ADDR_STATUS, 32'h0);
    chk(rd, 32'h2);
    wrap_up();
  end
endmodule
`default_nettype wire
